// *** rtl/ufn_frame_numbering.sv ***
// frame counter, frame timer, periodic-priority threshold and register port
`default_nettype none
// Behaviour
// - sixteen-bit read-only frame counter in low half, upper half reads zero
// - frame counter increments whenever the frame timer reloads the interval while operational
// - frame counter rolls from FFFF to zero
// - entering operational state increments frame counter once
// - frame count written to HCCA after increment and SOF, before first descriptor
// - start-of-frame status set after HCCA write completes
// - fourteen-bit software-writable periodic threshold in low bits
// - reset clears the periodic threshold to zero
// - at threshold, periodic lists take priority for rest of frame
// - current control or bulk transaction completes before interrupt list walk
// - frame timer counts down per bit time, reloads at next tick after zero
// - frame interval has nominal reset value 11999
module ufn_frame_numbering #(
	parameter int                 BIT_DIV  = ufn_pkg::BIT_TICK_CYCLES,
	parameter logic [13:0]        INTERVAL = ufn_pkg::INTERVAL_NOMINAL
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	output logic                  irq,
	output logic                  sof_send,
	input  wire logic             sof_done,
	output logic                  hcca_wr,
	output logic      [15:0]      hcca_frame,
	input  wire logic             hcca_ack,
	output logic                  ed_fetch_ok,
	input  wire logic             async_busy,
	output logic                  periodic_priority,
	output logic                  periodic_go,
	output logic      [13:0]      frame_remaining
);
	// ==========================================================
	// bit-time tick divider
	logic [7:0] div_cnt;
	logic       bit_tick;
	assign bit_tick = (div_cnt == 8'(BIT_DIV - 1));
	always_ff @(posedge sys_clk) begin
		if (!nrst || bit_tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// ==========================================================
	// register decode
	logic                                  wr_ctrl;
	logic                                  wr_thr;
	logic                                  wr_mask;
	logic                                  wr_stat;
	logic                                  oper;
	logic                                  oper_q;
	logic                                  oper_enter;
	logic [ufn_pkg::THRESHOLD_W-1:0]       periodic_threshold_field;
	logic [ufn_pkg::FRAME_COUNT_W-1:0]     frame_count_field;
	logic [ufn_pkg::INT_W-1:0]             int_status;
	logic [ufn_pkg::INT_W-1:0]             int_mask;
	logic [ufn_pkg::INT_W-1:0]             int_set;
	assign wr_ctrl = reg_wr && (reg_addr == ufn_pkg::CONTROL_OFS);
	assign wr_thr  = reg_wr && (reg_addr == ufn_pkg::PERIODIC_START_THRESHOLD_OFS);
	assign wr_mask = reg_wr && (reg_addr == ufn_pkg::INT_MASK_OFS);
	assign wr_stat = reg_wr && (reg_addr == ufn_pkg::INT_STATUS_OFS);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			oper <= 1'b0;
		end else if (wr_ctrl) begin
			oper <= reg_wdata[ufn_pkg::CTRL_OPER_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			oper_q <= 1'b0;
		end else begin
			oper_q <= oper;
		end
	end
	assign oper_enter = oper && !oper_q;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			periodic_threshold_field <= ufn_pkg::THRESHOLD_RST;
		end else if (wr_thr) begin
			periodic_threshold_field <= reg_wdata[ufn_pkg::THRESHOLD_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			int_mask <= '0;
		end else if (wr_mask) begin
			int_mask <= reg_wdata[ufn_pkg::INT_W-1:0];
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status & ~(wr_stat ? reg_wdata[ufn_pkg::INT_W-1:0] : '0))
				| int_set;
		end
	end
	assign irq = |(int_status & int_mask);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ufn_pkg::FRAME_NUMBER_COUNT_OFS:       reg_rdata <= {16'h0000, frame_count_field};
				ufn_pkg::PERIODIC_START_THRESHOLD_OFS: reg_rdata <= {18'h00000, periodic_threshold_field};
				ufn_pkg::INT_STATUS_OFS:               reg_rdata <= {30'h0, int_status};
				ufn_pkg::INT_MASK_OFS:                 reg_rdata <= {30'h0, int_mask};
				ufn_pkg::CONTROL_OFS:                  reg_rdata <= {31'h0, oper};
				default:                               reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// frame timer
	logic frame_boundary;
	assign frame_boundary = oper && bit_tick && (frame_remaining == 14'h0000);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			frame_remaining <= 14'h0000;
		end else if (!oper || oper_enter) begin
			frame_remaining <= INTERVAL;
		end else if (bit_tick) begin
			frame_remaining <= (frame_remaining == 14'h0000) ? INTERVAL : frame_remaining - 14'h0001;
		end
	end

	// ==========================================================
	// frame counter
	logic frame_step;
	assign frame_step = frame_boundary || oper_enter;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			frame_count_field <= ufn_pkg::FRAME_COUNT_RST;
		end else if (frame_step) begin
			frame_count_field <= frame_count_field + 16'h0001;
		end
	end

	// ==========================================================
	// frame-start sequence: SOF, HCCA write, flag
	ufn_pkg::ufn_state_t state;
	ufn_pkg::ufn_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ufn_pkg::UFN_IDLE: if (frame_step) next_state = ufn_pkg::UFN_SOF;
			ufn_pkg::UFN_SOF:  if (sof_done) next_state = ufn_pkg::UFN_HCCA;
			ufn_pkg::UFN_HCCA: if (hcca_ack) next_state = ufn_pkg::UFN_FLAG;
			ufn_pkg::UFN_FLAG: next_state = ufn_pkg::UFN_IDLE;
			default:           next_state = ufn_pkg::UFN_IDLE;
		endcase
		if (!oper) begin
			next_state = ufn_pkg::UFN_IDLE;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= ufn_pkg::UFN_IDLE;
		end else begin
			state <= next_state;
		end
	end
	assign sof_send    = (state == ufn_pkg::UFN_SOF);
	assign hcca_wr     = (state == ufn_pkg::UFN_HCCA);
	assign ed_fetch_ok = oper && !frame_step && (state == ufn_pkg::UFN_IDLE);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hcca_frame <= 16'h0000;
		end else if (state == ufn_pkg::UFN_SOF && sof_done) begin
			hcca_frame <= frame_count_field;
		end
	end

	// ==========================================================
	// periodic priority latch
	logic prio_hit;
	assign prio_hit = oper && bit_tick && !frame_boundary
		&& (frame_remaining == periodic_threshold_field);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			periodic_priority <= 1'b0;
		end else if (frame_boundary || !oper) begin
			periodic_priority <= 1'b0;
		end else if (prio_hit) begin
			periodic_priority <= 1'b1;
		end
	end
	assign periodic_go = periodic_priority && !async_busy;

	assign int_set[ufn_pkg::INT_SOF_BIT]      = (state == ufn_pkg::UFN_FLAG);
	assign int_set[ufn_pkg::INT_PERIODIC_BIT] = prio_hit;

	// ==========================================================
	// checks
	sequence s_sof_to_hcca;
		sof_send ##1 (!sof_send && hcca_wr);
	endsequence
	sequence s_flag_to_status;
		int_set[ufn_pkg::INT_SOF_BIT] ##1 int_status[ufn_pkg::INT_SOF_BIT];
	endsequence

	// bit ticks since the last frame start, for the frame length check
	logic [14:0] tick_seen;
	always_ff @(posedge sys_clk) begin
		if (!nrst || !oper || frame_step) begin
			tick_seen <= 15'h0000;
		end else if (bit_tick) begin
			tick_seen <= tick_seen + 15'h0001;
		end
	end
	chk_sof_after_hcca: assert property (@(posedge sys_clk) disable iff (!nrst)
		(hcca_wr && hcca_ack && oper) |=> s_flag_to_status)
		else $error("sof flag not set after hcca write");
	chk_hcca_after_sof: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(hcca_wr) |-> $past(sof_send))
		else $error("hcca write before sof");
	chk_no_ed_in_seq: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sof_send || hcca_wr) |-> !ed_fetch_ok)
		else $error("descriptor fetch allowed during frame start");
	chk_count_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		frame_boundary |=> frame_count_field == $past(frame_count_field) + 16'h0001)
		else $error("frame count not incremented");
	chk_count_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		!frame_step |=> $stable(frame_count_field))
		else $error("frame count moved without boundary");
	chk_oper_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		oper_enter |=> frame_count_field == $past(frame_count_field) + 16'h0001)
		else $error("no increment on operational entry");
	chk_reload_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_boundary && !oper_enter && !wr_ctrl) |=> frame_remaining == INTERVAL)
		else $error("frame timer not reloaded");
	chk_prio_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
		(prio_hit && !wr_ctrl) |=> periodic_priority)
		else $error("periodic priority not latched");
	chk_prio_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		frame_boundary |=> !periodic_priority)
		else $error("periodic priority held past boundary");
	chk_async_finish: assert property (@(posedge sys_clk) disable iff (!nrst)
		async_busy |-> !periodic_go)
		else $error("periodic walk started during async transaction");
	chk_thr_write: assert property (@(posedge sys_clk) disable iff (!nrst)
		wr_thr |=> periodic_threshold_field == $past(reg_wdata[13:0]))
		else $error("threshold write lost");
	chk_frame_read: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && reg_addr == ufn_pkg::FRAME_NUMBER_COUNT_OFS) |=> reg_rdata[31:16] == 16'h0000)
		else $error("frame number upper half not zero");
	chk_sof_seq: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sof_send && sof_done && oper) |-> s_sof_to_hcca)
		else $error("hcca write did not follow sof");
	chk_div_range: assert property (@(posedge sys_clk) disable iff (!nrst)
		div_cnt <= 8'(BIT_DIV - 1))
		else $error("bit tick divider out of range");
	chk_timer_dec: assert property (@(posedge sys_clk) disable iff (!nrst)
		(oper && !oper_enter && bit_tick && frame_remaining != 14'h0000)
			|=> frame_remaining == $past(frame_remaining) - 14'h0001)
		else $error("frame timer did not count down");
	chk_timer_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(oper && !oper_enter && !bit_tick) |=> $stable(frame_remaining))
		else $error("frame timer moved between ticks");
	chk_timer_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
		!oper |=> frame_remaining == INTERVAL)
		else $error("frame timer not at interval while stopped");
	chk_enter_reload: assert property (@(posedge sys_clk) disable iff (!nrst)
		oper_enter |=> frame_remaining == INTERVAL)
		else $error("frame timer not reloaded on entry");
	chk_frame_length: assert property (@(posedge sys_clk) disable iff (!nrst)
		frame_boundary |-> tick_seen == {1'b0, INTERVAL})
		else $error("frame length differs from interval");
	chk_count_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_step && frame_count_field == 16'hFFFF) |=> frame_count_field == 16'h0000)
		else $error("frame count did not roll over");
	chk_frame_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && reg_addr == ufn_pkg::FRAME_NUMBER_COUNT_OFS)
			|=> reg_rdata[15:0] == $past(frame_count_field))
		else $error("frame count read wrong");
	chk_thr_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		!wr_thr |=> $stable(periodic_threshold_field))
		else $error("threshold changed without write");
	chk_thr_read: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && reg_addr == ufn_pkg::PERIODIC_START_THRESHOLD_OFS)
			|=> reg_rdata == {18'h00000, $past(periodic_threshold_field)})
		else $error("threshold read wrong");
	chk_prio_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(periodic_priority && oper && !frame_boundary) |=> periodic_priority)
		else $error("periodic priority dropped inside frame");
	chk_prio_only_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!periodic_priority && !prio_hit) |=> !periodic_priority)
		else $error("periodic priority set without threshold");
	chk_prio_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
		!oper |=> !periodic_priority)
		else $error("periodic priority while stopped");
	chk_prio_status: assert property (@(posedge sys_clk) disable iff (!nrst)
		int_set[ufn_pkg::INT_PERIODIC_BIT] |=> int_status[ufn_pkg::INT_PERIODIC_BIT])
		else $error("threshold status not set");
	chk_go_needs_prio: assert property (@(posedge sys_clk) disable iff (!nrst)
		periodic_go |-> periodic_priority)
		else $error("periodic walk without priority");
	chk_go_when_free: assert property (@(posedge sys_clk) disable iff (!nrst)
		(periodic_priority && !async_busy) |-> periodic_go)
		else $error("periodic walk held back when free");
	chk_step_starts: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_step && state == ufn_pkg::UFN_IDLE) |=> sof_send)
		else $error("frame start did not request sof");
	chk_sof_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sof_send && !sof_done && oper) |=> sof_send)
		else $error("sof request dropped early");
	chk_hcca_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(hcca_wr && !hcca_ack && oper) |=> hcca_wr)
		else $error("hcca write dropped early");
	chk_hcca_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		($rose(hcca_wr) && !$past(frame_step))
			|-> hcca_frame == frame_count_field)
		else $error("hcca frame differs from counter");
	chk_no_fetch_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		frame_step |-> !ed_fetch_ok)
		else $error("descriptor fetch allowed at frame boundary");
	chk_flag_once: assert property (@(posedge sys_clk) disable iff (!nrst)
		int_set[ufn_pkg::INT_SOF_BIT] |=> !int_set[ufn_pkg::INT_SOF_BIT])
		else $error("sof flag state held too long");
	chk_set_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
		int_set[ufn_pkg::INT_SOF_BIT] |=> int_status[ufn_pkg::INT_SOF_BIT])
		else $error("sof flag lost to clear");
	chk_status_w1c: assert property (@(posedge sys_clk) disable iff (!nrst)
		(wr_stat && reg_wdata[ufn_pkg::INT_SOF_BIT] && !int_set[ufn_pkg::INT_SOF_BIT])
			|=> !int_status[ufn_pkg::INT_SOF_BIT])
		else $error("sof flag not cleared by write one");
	chk_irq_sof: assert property (@(posedge sys_clk) disable iff (!nrst)
		(int_status[ufn_pkg::INT_SOF_BIT] && int_mask[ufn_pkg::INT_SOF_BIT]) |-> irq)
		else $error("unmasked sof flag without interrupt");
endmodule
`default_nettype wire

// *** rtl/ufn_pkg.sv ***
// constants for the frame numbering and periodic threshold block
`default_nettype none
package ufn_pkg;
	// register byte offsets
	localparam logic [7:0] FRAME_NUMBER_COUNT_OFS       = 8'h3C;
	localparam logic [7:0] PERIODIC_START_THRESHOLD_OFS = 8'h40;
	localparam logic [7:0] INT_STATUS_OFS               = 8'h48;
	localparam logic [7:0] INT_MASK_OFS                 = 8'h4C;
	localparam logic [7:0] CONTROL_OFS                  = 8'h50;
	// field layout
	localparam int FRAME_COUNT_W     = 16;
	localparam int THRESHOLD_W       = 14;
	localparam int INTERVAL_W        = 14;
	localparam int INT_W             = 2;
	localparam int INT_SOF_BIT       = 0;
	localparam int INT_PERIODIC_BIT  = 1;
	localparam int CTRL_OPER_BIT     = 0;
	// reset values
	localparam logic [15:0] FRAME_COUNT_RST  = 16'h0000;
	localparam logic [13:0] THRESHOLD_RST    = 14'h0000;
	localparam logic [13:0] INTERVAL_NOMINAL = 14'h2EDF;
	// timing: 12 Mbit/s bit time against the 200 MHz clock
	localparam int SYS_CLK_KHZ       = 200000;
	localparam int BIT_RATE_KHZ      = 12000;
	localparam int BIT_TICK_CYCLES   = SYS_CLK_KHZ / BIT_RATE_KHZ;
	// frame-start sequencing states
	typedef enum logic [1:0] {
		UFN_IDLE  = 2'b00,
		UFN_SOF   = 2'b01,
		UFN_HCCA  = 2'b10,
		UFN_FLAG  = 2'b11
	} ufn_state_t;
endpackage
`default_nettype wire

// *** bench/ufn_far_side.sv ***
// model of the bus schedule and HCCA memory beyond the frame block
`default_nettype none
module ufn_far_side (
	input  wire logic        sys_clk,
	input  wire logic        slow,
	input  wire logic        sof_send,
	output logic             sof_done,
	input  wire logic        hcca_wr,
	input  wire logic [15:0] hcca_frame,
	output logic             hcca_ack,
	output logic      [15:0] last_frame,
	output int               n_writes
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================
	// sof transmission
	initial begin
		sof_done = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (sof_send) begin
				repeat (slow ? 6 : 1) @(posedge sys_clk);
				sof_done <= 1'b1;
				@(posedge sys_clk);
				sof_done <= 1'b0;
				@(posedge sys_clk);
			end
		end
	end
	// =========================
	// hcca memory write
	initial begin
		hcca_ack = 1'b0;
		last_frame = 16'hFFFF;
		n_writes = 0;
		forever begin
			@(posedge sys_clk);
			if (hcca_wr) begin
				repeat (slow ? 5 : 1) @(posedge sys_clk);
				hcca_ack <= 1'b1;
				last_frame <= hcca_frame;
				n_writes <= n_writes + 1;
				@(posedge sys_clk);
				hcca_ack <= 1'b0;
				@(posedge sys_clk);
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// register-level test of the frame numbering block
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        irq, sof_send, sof_done, hcca_wr, hcca_ack;
	logic [15:0] hcca_frame, last_frame;
	logic        ed_fetch_ok, periodic_priority, periodic_go;
	logic        async_busy = 1'b0;
	logic        slow = 1'b0;
	logic [13:0] frame_remaining;
	logic [31:0] rv;
	int          n_writes, err_total = 0, n_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	ufn_frame_numbering #(.BIT_DIV(2), .INTERVAL(14'h00C8)) dut (.sys_clk(sys_clk),
		.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sof_send(sof_send),
		.sof_done(sof_done), .hcca_wr(hcca_wr), .hcca_frame(hcca_frame),
		.hcca_ack(hcca_ack), .ed_fetch_ok(ed_fetch_ok), .async_busy(async_busy),
		.periodic_priority(periodic_priority), .periodic_go(periodic_go),
		.frame_remaining(frame_remaining));
	ufn_far_side far (.sys_clk(sys_clk), .slow(slow), .sof_send(sof_send),
		.sof_done(sof_done), .hcca_wr(hcca_wr), .hcca_frame(hcca_frame),
		.hcca_ack(hcca_ack), .last_frame(last_frame), .n_writes(n_writes));
	// =========================
	// register access
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic wait_writes(input int n);
		for (int i = 0; i < 1000 && n_writes < n; i++) @(posedge sys_clk);
		`CHK("hcca writes", n, n_writes)
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// =========================
	// watchdog
	initial begin
		repeat (3000) @(posedge sys_clk);
		err_total++;
		stop_test();
	end
	// =========================
	// tests
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(8'h3C); `CHK("count rst", 32'h0, rv)
		rd(8'h40); `CHK("thr rst", 32'h0, rv)
		rd(8'h10); `CHK("unmapped", 32'h0, rv)
		`CHK("interval", 14'h00C8, frame_remaining)
		wr(8'h3C, 32'h0000_1234);
		rd(8'h3C); `CHK("count ro", 32'h0, rv)
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40); `CHK("thr width", 32'h0000_3FFF, rv)
		wr(8'h40, 32'h0000_00B4);
		wr(8'h4C, 32'h0000_0001);
		async_busy <= 1'b1;
		wr(8'h50, 32'h0000_0001);
		wait_writes(1);
		`CHK("hcca 1", 16'h0001, last_frame)
		`CHK("sof irq", 1'b1, irq)
		`CHK("fetch ok", 1'b1, ed_fetch_ok)
		rd(8'h3C); `CHK("count 1", 32'h1, rv)
		wr(8'h48, 32'h0000_0001);
		rd(8'h48); `CHK("sof w1c", 1'b0, rv[0])
		`CHK("irq low", 1'b0, irq)
		for (int i = 0; i < 200 && periodic_priority !== 1'b1; i++) @(posedge sys_clk);
		#1 `CHK("prio", 1'b1, periodic_priority)
		`CHK("go busy", 1'b0, periodic_go)
		`CHK("remaining", 14'h00B3, frame_remaining)
		@(posedge sys_clk);
		async_busy <= 1'b0;
		@(posedge sys_clk);
		#1 `CHK("go free", 1'b1, periodic_go)
		rd(8'h48); `CHK("prio stat", 1'b1, rv[1])
		slow <= 1'b1;
		wait_writes(2);
		`CHK("prio clr", 1'b0, periodic_priority)
		`CHK("hcca 2", 16'h0002, last_frame)
		rd(8'h3C); `CHK("count 2", 32'h2, rv)
		wr(8'h50, 32'h0);
		@(posedge sys_clk);
		#1 `CHK("stop fetch", 1'b0, ed_fetch_ok)
		stop_test();
	end
endmodule
`default_nettype wire
